/* File: hdl/gpc_ctrl.v */
// controller side of an instrument bus interface: status, mask, polls
// assumes host register port on clk_i; bus lines are open-drain pins
// Function
// - programming the interrupt mask stores it in the enable register
// - mask bit 1 enables service-request interrupts; reads back as 2
// - service request is level sensed; short pulses raise nothing
// - after one logged interrupt no more until serviced and re-enabled
// - parallel-poll setup addresses one listener per sequence
// - parallel poll returns one byte of up to 8 status bits
// - parallel poll only while active controller
// - disable without address clears all; with address only that device
// - serial poll only as active controller, to one device address
// - status bit 7 system controller, bit 6 active, bit 5 zero
// - status bits 4..0 hold the primary address 0 to 30
// - power-on address 21 if system controller, else 20
// - written address above 30 taken modulo 32, 31 never used
// - one system controller per bus is recommended
// - pass control: address candidate to talk, send take-control
// - take-control is command code 9 right after talk address
// - cause bits share positions with enable mask bits
`timescale 1ns/10ps
`include "gpc_defines.vh"
module gpc_ctrl #(
    parameter CLK_MHZ = 50
) (
    input  wire        clk_i,
    input  wire        sys_rst_i,
    input  wire        sys_ctrl_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    output reg  [15:0] reg_rdata_o,
    output wire        busy_o,
    output reg         irq_o,
    input  wire [7:0]  dio_i,
    output reg  [7:0]  dio_o,
    output reg         dio_oe_o,
    output reg         atn_o,
    output reg         eoi_o,
    output reg         handshake_o,
    input  wire        srq_i,
    input  wire        accept_i
);
    localparam PP_CYC_RAW = (`GPC_PP_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam [7:0] PP_CYC = (PP_CYC_RAW < 1) ? 8'd1 : PP_CYC_RAW[7:0];
    localparam S_IDLE = 3'd0;
    localparam S_SEND = 3'd1;
    localparam S_PPWAIT = 3'd2;
    localparam S_SPREAD = 3'd3;
    localparam S_DONE = 3'd4;

    wire [7:0] dio_s;
    wire       srq_s;
    wire       acc_s;
    wire       sys_s;
    // strap is a pin too, so it rides the same synchroniser
    gpc_sync #(.W(11)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       ({dio_i, srq_i, accept_i, sys_ctrl_i}),
        .q_o       ({dio_s, srq_s, acc_s, sys_s})
    );

    reg [1:0]  init_q;
    reg        sys_q;
    reg        act_q;
    reg [4:0]  addr_q;
    reg [15:0] mask_q;
    reg [15:0] cause_q;
    reg        logged_q;
    reg [2:0]  st_q;
    reg [2:0]  op_q;
    reg [8:0]  arg_q;
    reg [7:0]  res_q;
    reg [2:0]  idx_q;
    reg [2:0]  len_q;
    reg [7:0]  cnt_q;
    reg        pass_q;

    wire [4:0] wr_addr = reg_wdata_i[4:0];
    wire       cmd_go = reg_wr_i && (reg_addr_i == `GPC_REG_CMD);
    wire       may_run = act_q && (st_q == S_IDLE);
    wire       addr_ok = (arg_q[4:0] != `GPC_ADDR_UNUSED);
    assign busy_o = (st_q != S_IDLE);

    // byte sequence per operation; commands with attention asserted
    reg [7:0] seq_byte;
    always @*
    begin
        seq_byte = `GPC_CMD_UNL;
        case (op_q)
            `GPC_OP_PP_SETUP:
                // one listener per setup; mode byte carries sense+line
                if (idx_q == 3'd0) seq_byte = `GPC_CMD_UNL;
                else if (idx_q == 3'd1) seq_byte = {3'b001, arg_q[4:0]};
                else if (idx_q == 3'd2) seq_byte = `GPC_CMD_PPC;
                else seq_byte = {4'h6, arg_q[8], arg_q[7:5]};
            `GPC_OP_PP_DISABLE:
                if (addr_ok)
                begin
                    if (idx_q == 3'd0) seq_byte = `GPC_CMD_UNL;
                    else if (idx_q == 3'd1) seq_byte = {3'b001, arg_q[4:0]};
                    else if (idx_q == 3'd2) seq_byte = `GPC_CMD_PPC;
                    else seq_byte = `GPC_CMD_PPD;
                end
                else
                    seq_byte = `GPC_CMD_PPU;
            `GPC_OP_SP_QUERY:
                if (idx_q == 3'd0) seq_byte = `GPC_CMD_UNL;
                else if (idx_q == 3'd1) seq_byte = `GPC_CMD_SPE;
                else seq_byte = {3'b010, arg_q[4:0]};
            `GPC_OP_PASS_CTRL:
                if (idx_q == 3'd0) seq_byte = {3'b010, arg_q[4:0]};
                else seq_byte = `GPC_CMD_TCT;
            default:
                seq_byte = `GPC_CMD_UNL;
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            init_q      <= 2'd3;
            sys_q       <= 1'b0;
            act_q       <= 1'b0;
            addr_q      <= `GPC_ADDR_DEV_RST;
            mask_q      <= `GPC_MASK_RST;
            cause_q     <= 16'h0000;
            logged_q    <= 1'b0;
            st_q        <= S_IDLE;
            op_q        <= 3'h0;
            arg_q       <= 9'h000;
            res_q       <= 8'h00;
            idx_q       <= 3'd0;
            len_q       <= 3'd0;
            cnt_q       <= 8'h00;
            pass_q      <= 1'b0;
            dio_o       <= 8'h00;
            dio_oe_o    <= 1'b0;
            atn_o       <= 1'b0;
            eoi_o       <= 1'b0;
            handshake_o <= 1'b0;
            irq_o       <= 1'b0;
            reg_rdata_o <= 16'h0000;
        end
        else
        begin
            // strap caught once its synchroniser has filled
            if (init_q != 2'd0)
                init_q <= init_q - 2'd1;
            if (init_q == 2'd1)
            begin
                sys_q  <= sys_s;
                act_q  <= sys_s;
                addr_q <= sys_s ? `GPC_ADDR_SYS_RST
                                : `GPC_ADDR_DEV_RST;
            end
            if (reg_wr_i && reg_addr_i == `GPC_REG_INT_MASK)
            begin
                mask_q   <= reg_wdata_i;
                logged_q <= 1'b0;
            end
            if (reg_wr_i && reg_addr_i == `GPC_REG_ADDR_WR)
                addr_q <= (wr_addr == `GPC_ADDR_UNUSED) ? 5'h00
                                                        : wr_addr;
            if (reg_wr_i && reg_addr_i == `GPC_REG_CMD_ARG)
                arg_q <= reg_wdata_i[8:0];
            // cause latches sampled level only; first one blocks rest
            if (!logged_q && srq_s && mask_q[`GPC_BIT_SRQ])
            begin
                cause_q[`GPC_BIT_SRQ] <= 1'b1;
                logged_q <= 1'b1;
            end
            else if (reg_rd_i && reg_addr_i == `GPC_REG_INT_CAUSE)
                cause_q <= 16'h0000;
            irq_o <= |(cause_q & mask_q);
            if (reg_rd_i)
            begin
                if (reg_addr_i == `GPC_REG_ROLE_ADDR)
                    reg_rdata_o <= {8'h00, sys_q, act_q, 1'b0,
                                    addr_q};
                else if (reg_addr_i == `GPC_REG_INT_MASK)
                    reg_rdata_o <= mask_q;
                else if (reg_addr_i == `GPC_REG_INT_CAUSE)
                    reg_rdata_o <= cause_q;
                else if (reg_addr_i == `GPC_REG_RESULT)
                    reg_rdata_o <= {7'h00, busy_o, res_q};
                else
                    reg_rdata_o <= 16'h0000;
            end
            case (st_q)
                S_IDLE:
                begin
                    handshake_o <= 1'b0;
                    if (cmd_go && may_run)
                    begin
                        op_q  <= reg_wdata_i[2:0];
                        idx_q <= 3'd0;
                        pass_q <= 1'b0;
                        case (reg_wdata_i[2:0])
                            `GPC_OP_PP_QUERY:
                            begin
                                atn_o    <= 1'b1;
                                eoi_o    <= 1'b1;
                                cnt_q    <= PP_CYC;
                                st_q     <= S_PPWAIT;
                            end
                            `GPC_OP_PP_SETUP:
                            begin
                                len_q <= 3'd3;
                                st_q  <= S_SEND;
                            end
                            `GPC_OP_PP_DISABLE:
                            begin
                                len_q <= addr_ok ? 3'd3 : 3'd0;
                                st_q  <= S_SEND;
                            end
                            `GPC_OP_SP_QUERY:
                            begin
                                len_q <= 3'd2;
                                // serial poll to address 31 is refused: stays in S_IDLE
                                st_q  <= addr_ok ? S_SEND : S_IDLE;
                            end
                            `GPC_OP_PASS_CTRL:
                            begin
                                len_q <= 3'd1;
                                st_q  <= S_SEND;
                            end
                            default:
                                st_q <= S_IDLE;
                        endcase
                    end
                end
                S_SEND:
                begin
                    // one byte per two cycles: strobe high, then low
                    atn_o    <= 1'b1;
                    dio_oe_o <= 1'b1;
                    dio_o    <= seq_byte;
                    handshake_o <= ~handshake_o;
                    if (handshake_o)
                    begin
                        if (idx_q == len_q)
                        begin
                            dio_oe_o <= 1'b0;
                            atn_o    <= 1'b0;
                            if (op_q == `GPC_OP_SP_QUERY)
                                st_q <= S_SPREAD;
                            else if (op_q == `GPC_OP_PASS_CTRL)
                            begin
                                pass_q <= 1'b1;
                                st_q   <= S_DONE;
                            end
                            else
                                st_q <= S_DONE;
                        end
                        else
                            idx_q <= idx_q + 3'd1;
                    end
                end
                S_PPWAIT:
                begin
                    cnt_q <= cnt_q - 8'd1;
                    if (cnt_q == 8'd1)
                    begin
                        res_q <= dio_s;
                        atn_o <= 1'b0;
                        eoi_o <= 1'b0;
                        st_q  <= S_DONE;
                    end
                end
                S_SPREAD:
                begin
                    // status byte taken when device marks it valid
                    if (acc_s)
                    begin
                        res_q <= dio_s;
                        idx_q <= 3'd0;
                        op_q  <= 3'h0;
                        st_q  <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    handshake_o <= 1'b0;
                    // candidate confirms by accept line
                    if (pass_q && acc_s)
                        act_q <= 1'b0;
                    st_q <= S_IDLE;
                end
                default:
                    st_q <= S_IDLE;
            endcase
        end
    end
endmodule // gpc_ctrl

/* File: hdl/gpc_defines.vh */
// constants of the bus controller: register indices, fields, resets
// assumes a 50 MHz clock and no other bus than the register port
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
`define GPC_REG_ROLE_ADDR   4'h3
`define GPC_REG_INT_MASK    4'h4
`define GPC_REG_INT_CAUSE   4'h5
`define GPC_REG_ADDR_WR     4'h6
`define GPC_REG_CMD         4'h7
`define GPC_REG_CMD_ARG     4'h8
`define GPC_REG_RESULT      4'h9
`define GPC_BIT_SYS_CTRL    7
`define GPC_BIT_ACT_CTRL    6
`define GPC_BIT_SRQ         1
`define GPC_ADDR_SYS_RST    5'h15
`define GPC_ADDR_DEV_RST    5'h14
`define GPC_ADDR_UNUSED     5'h1f
`define GPC_MASK_RST        16'h0000
`define GPC_CMD_TCT         8'h09
`define GPC_CMD_PPC         8'h05
`define GPC_CMD_PPU         8'h15
`define GPC_CMD_PPD         8'h70
`define GPC_CMD_SPE         8'h18
`define GPC_CMD_SPD         8'h19
`define GPC_CMD_UNL         8'h3f
`define GPC_CMD_UNT         8'h5f
`define GPC_OP_PP_QUERY     3'h1
`define GPC_OP_PP_SETUP     3'h2
`define GPC_OP_PP_DISABLE   3'h3
`define GPC_OP_SP_QUERY     3'h4
`define GPC_OP_PASS_CTRL    3'h5
`define GPC_PP_SETTLE_NS    2000
`endif

/* File: hdl/gpc_sync.v */
// two flip-flop synchroniser for bus lines arriving from pins
// assumes asynchronous active-high reset and one clock
`timescale 1ns/10ps
module gpc_sync #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         sys_rst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    always @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end
    assign q_o = s2_q;
endmodule // gpc_sync

/* File: tb/gpc_props.sv */
// checker: status, mask, interrupt and byte timing at the ports
// assumes one clock domain and the register indices of the design
`timescale 1ns/10ps
module gpc_props (
    input wire        clk_i,
    input wire        sys_rst_i,
    input wire        sys_ctrl_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [3:0]  reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    input wire        irq_o,
    input wire [7:0]  dio_o,
    input wire        dio_oe_o,
    input wire        handshake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire rd3 = reg_rd_i && reg_addr_i == 4'h3;
    wire mwr = reg_wr_i && reg_addr_i == 4'h4;
    wire svc = mwr || (reg_rd_i && reg_addr_i == 4'h5);
    sequence s_mask_wr; mwr; endsequence
    sequence s_mask_rd; reg_rd_i && reg_addr_i == 4'h4; endsequence
    a_status_fixed_zero: assert property (rd3 |=>
        reg_rdata_o[5] == 1'b0 && reg_rdata_o[15:8] == 8'h00)
        else $error("status zero bits set");
    a_addr_never_31: assert property (rd3 |=>
        reg_rdata_o[4:0] != 5'h1f) else $error("address 31 reported");
    a_sys_ctrl_bit: assert property (rd3 |=>
        reg_rdata_o[7] == $past(sys_ctrl_i)) else $error("role bit wrong");
    a_mask_read_back: assert property (s_mask_wr ##2 s_mask_rd |=>
        reg_rdata_o == $past(reg_wdata_i, 3)) else $error("mask lost");
    a_irq_holds_level: assert property (irq_o && !svc && !$past(svc)
        |=> irq_o) else $error("irq dropped unserviced");
    a_irq_masked_off: assert property ((mwr && reg_wdata_i == 16'h0)
        ##1 !svc |=> !irq_o) else $error("irq with zero mask");
    a_hs_one_cycle: assert property (handshake_o |=> !handshake_o)
        else $error("handshake longer than a cycle");
    // byte goes out with the strobe and stays through its low half
    a_byte_held: assert property ($fell(handshake_o) |->
        $stable(dio_o) && $past(dio_oe_o)) else $error("byte not held");
endmodule // gpc_props
bind gpc_ctrl gpc_props gpc_props_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .sys_ctrl_i(sys_ctrl_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .irq_o(irq_o),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .dio_o(dio_o),
    .dio_oe_o(dio_oe_o), .handshake_o(handshake_o));

/* File: tb/gpc_bus_model.sv */
// instruments on the bus: poll answers and control acceptance
// assumes pulled-up lines, so a released data bus reads all ones
`timescale 1ns/10ps
module gpc_bus_model (
    input  wire       clk_i,
    input  wire       dio_oe_o,
    input  wire       atn_o,
    input  wire       eoi_o,
    input  wire       handshake_o,
    input  wire [7:0] pp_resp_i,
    input  wire [7:0] status_i,
    input  wire       slow_i,
    input  wire       accept_en_i,
    output wire [7:0] dio_i,
    output wire       accept_i
);
    reg [5:0] gap_q = 6'h0;
    always @(posedge clk_i)
        gap_q <= handshake_o ? 6'h0 : gap_q + {5'h0, gap_q != 6'h3f};
    // slow device answers only more than 20 cycles after the last strobe
    assign accept_i = accept_en_i && (!slow_i || gap_q > 6'h14);
    assign dio_i = (atn_o && eoi_o) ? pp_resp_i :
                   (accept_i && !dio_oe_o && !atn_o) ? status_i :
                   8'hff;
endmodule // gpc_bus_model

/* File: tb/tb_top.sv */
// self-checking bench: registers, service requests, polls, pass control
// assumes gpc_ctrl and the bus model; inputs change at the falling edge, except the short srq_i pulse
`timescale 1ns/10ps
module tb_top;
    reg         clk_i = 1'b0;
    reg         sys_rst_i = 1'b1;
    reg         sys_ctrl_i = 1'b1;
    reg         reg_wr_i = 1'b0;
    reg         reg_rd_i = 1'b0;
    reg  [3:0]  reg_addr_i = 4'h0;
    reg  [15:0] reg_wdata_i = 16'h0;
    reg         srq_i = 1'b0;
    reg  [7:0]  pp_resp = 8'h0;
    reg  [7:0]  status = 8'h0;
    reg         slow = 1'b0;
    reg         acc_en = 1'b0;
    wire [15:0] reg_rdata_o;
    wire        busy_o, irq_o, dio_oe_o, atn_o, eoi_o, handshake_o, acc;
    wire [7:0]  dio_i, dio_o;
    integer     num_errors = 0, comparisons = 0, cyc = 0, i, j;
    reg  [15:0] v;
    reg  [7:0]  w;
    reg  [7:0]  sent[$];
    gpc_ctrl gpc_ctrl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .sys_ctrl_i(sys_ctrl_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .busy_o(busy_o), .irq_o(irq_o),
        .dio_i(dio_i), .dio_o(dio_o), .dio_oe_o(dio_oe_o), .atn_o(atn_o),
        .eoi_o(eoi_o), .handshake_o(handshake_o), .srq_i(srq_i),
        .accept_i(acc));
    gpc_bus_model gpc_bus_model_inst (.clk_i(clk_i), .dio_oe_o(dio_oe_o),
        .atn_o(atn_o), .eoi_o(eoi_o), .handshake_o(handshake_o),
        .pp_resp_i(pp_resp), .status_i(status), .slow_i(slow),
        .accept_en_i(acc_en), .dio_i(dio_i), .accept_i(acc));
    initial forever #10 clk_i = ~clk_i;
    task stop_test;
        begin
            $display("comparisons %0d errors %0d", comparisons, num_errors);
            if (num_errors == 0 && comparisons > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (handshake_o && dio_oe_o)
            sent.push_back(dio_o);
        // run is under a thousand cycles; this bound only cuts a hang
        if (cyc == 20000)
        begin
            num_errors++;
            stop_test;
        end
    end
    task check(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                num_errors++;
                $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    function [15:0] st(input s, input a, input [4:0] ad);
        st = {8'h0, s, a, 1'b0, ad};
    endfunction
    function [15:0] has(input [7:0] b);
        has = 16'h0;
        foreach (sent[k])
            if (sent[k] === b)
                has = 16'h1;
    endfunction
    // one idle cycle then one strobe cycle; read data lands meanwhile
    task xfer(input wr, input [3:0] a, input [15:0] d);
        begin
            @(negedge clk_i);
            reg_wr_i = wr;
            reg_rd_i = !wr;
            reg_addr_i = a;
            reg_wdata_i = d;
            @(negedge clk_i);
            reg_wr_i = 1'b0;
            reg_rd_i = 1'b0;
            v = reg_rdata_o;
        end
    endtask
    task cmd(input [2:0] op, input [15:0] arg);
        begin
            xfer(1, 4'h8, arg);
            sent.delete();
            xfer(1, 4'h7, {13'h0, op});
            for (i = 0; i < 400 && busy_o !== 1'b0; i++)
                @(negedge clk_i);
            xfer(0, 4'h9, 16'h0);
        end
    endtask
    task rst(input s);
        begin
            sys_ctrl_i = s;
            sys_rst_i = 1'b1;
            repeat (3) @(negedge clk_i);
            sys_rst_i = 1'b0;
            repeat (2) @(negedge clk_i);
        end
    endtask
    initial
    begin
        void'($urandom(32'h08a0));
        rst(1'b1);
        xfer(0, 4'h3, 16'h0);
        check("status", v, st(1, 1, 5'h15));
        xfer(1, 4'h4, 16'h0002);
        xfer(0, 4'h4, 16'h0);
        check("mask", v, 16'h0002);
        for (j = 0; j < 8; j++)
        begin
            w = j == 0 ? 8'h20 : j == 1 ? 8'h3e : j == 2 ? 8'h1e : $urandom;
            w = w[4:0] == 5'h1f ? w - 8'h1 : w;
            xfer(1, 4'h6, {8'h0, w});
            xfer(0, 4'h3, 16'h0);
            check("address", v, st(1, 1, w[4:0]));
        end
        // 63 folds onto 31, which must never be taken
        xfer(1, 4'h6, 16'h003f);
        xfer(0, 4'h3, 16'h0);
        check("address 31", v[4:0] == 5'h1f, 16'h0);
        @(negedge clk_i);
        #2 srq_i = 1'b1;
        #5 srq_i = 1'b0;
        repeat (8) @(negedge clk_i);
        check("short srq", irq_o, 16'h0);
        srq_i = 1'b1;
        repeat (8) @(negedge clk_i);
        check("irq", irq_o, 16'h1);
        xfer(0, 4'h5, 16'h0);
        check("cause", v, 16'h0002);
        repeat (8) @(negedge clk_i);
        check("irq locked", irq_o, 16'h0);
        xfer(1, 4'h4, 16'h0002);
        repeat (8) @(negedge clk_i);
        check("irq again", irq_o, 16'h1);
        srq_i = 1'b0;
        xfer(1, 4'h4, 16'h0);
        repeat (4) @(negedge clk_i);
        check("irq masked", irq_o, 16'h0);
        for (j = 0; j < 3; j++)
        begin
            pp_resp = $urandom;
            cmd(3'h1, 16'h0);
            check("pp byte", v, {8'h0, pp_resp});
        end
        cmd(3'h2, {8'h0, 3'h5, 5'h09});
        check("setup listen", has(8'h29) & has(8'h05), 16'h1);
        check("setup mode", has(8'h65), 16'h1);
        cmd(3'h2, {7'h0, 1'b1, 3'h5, 5'h09});
        check("setup sense", has(8'h6d), 16'h1);
        cmd(3'h3, 16'h001f);
        check("disable all", has(8'h15), 16'h1);
        cmd(3'h3, 16'h0005);
        check("disable one", has(8'h25) & has(8'h70), 16'h1);
        check("disable scope", has(8'h15), 16'h0);
        status = $urandom;
        slow = 1'b1;
        acc_en = 1'b1;
        cmd(3'h4, 16'h0007);
        check("serial_poll_query byte", v, {8'h0, status});
        check("serial_poll_query talk", has(8'h47) & has(8'h18), 16'h1);
        slow = 1'b0;
        xfer(1, 4'h8, 16'h001f);
        xfer(1, 4'h7, 16'h0004);
        check("serial_poll_query 31", busy_o, 16'h0);
        cmd(3'h5, 16'h0014);
        check("talk byte", sent[sent.size() - 2], 16'h0054);
        check("tct byte", sent[sent.size() - 1], 16'h0009);
        xfer(0, 4'h3, 16'h0);
        check("passed", v[6], 16'h0);
        xfer(1, 4'h7, 16'h0001);
        check("pp refused", busy_o, 16'h0);
        rst(1'b0);
        xfer(0, 4'h3, 16'h0);
        check("status dev", v, st(0, 0, 5'h14));
        stop_test;
    end
endmodule // tb_top
